// ---- design/pspp_pkg.sv ----
/*
  Constants, types and the capability table for the source power select
  and protection block.
  Assumes a single 100 MHz clock and no register bus.
*/
package pspp_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // Device variants
  localparam logic [1:0] VAR_ADJUST = 2'h0;
  localparam logic [1:0] VAR_FIXED  = 2'h1;
  localparam logic [1:0] VAR_HALVE  = 2'h2;

  // Select codes with a fixed meaning
  localparam logic [2:0] CODE_FULL = 3'h7;
  localparam logic [2:0] CODE_HALF = 3'h3;

  // Percent thresholds
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [7:0] PCT_OVP  = 8'h78;
  localparam logic [7:0] PCT_UVP  = 8'h41;
  localparam logic [7:0] PCT_OCP  = 8'h78;

  // Pin synchroniser settle time after reset release
  localparam logic [1:0] SETTLE_START = 2'h3;
  localparam logic [1:0] SETTLE_TAKE  = 2'h1;

  localparam int unsigned N_PDO = 5;

  typedef logic [N_PDO-1:0][8:0] pspp_cur_t;

  // Power in 0.1 W, currents in 10 mA for 5, 9, 12, 15, 20 V
  typedef struct packed {
    logic [9:0] pdp;
    pspp_cur_t  cur;
  } pspp_caps_t;

  localparam pspp_caps_t CAPS_TABLE [8] = '{
    '{pdp: 10'h0A0, cur: {9'h000, 9'h000, 9'h085, 9'h0B1, 9'h12C}},
    '{pdp: 10'h0A0, cur: {9'h000, 9'h000, 9'h085, 9'h0B1, 9'h12C}},
    '{pdp: 10'h0E1, cur: {9'h000, 9'h000, 9'h0B7, 9'h0F4, 9'h12C}},
    '{pdp: 10'h12C, cur: {9'h000, 9'h0C8, 9'h0FA, 9'h12C, 9'h12C}},
    '{pdp: 10'h177, cur: {9'h000, 9'h0F6, 9'h12C, 9'h12C, 9'h12C}},
    '{pdp: 10'h1C2, cur: {9'h0E1, 9'h12C, 9'h12C, 9'h12C, 9'h12C}},
    '{pdp: 10'h20D, cur: {9'h104, 9'h12C, 9'h12C, 9'h12C, 9'h12C}},
    '{pdp: 10'h258, cur: {9'h12C, 9'h12C, 9'h12C, 9'h12C, 9'h12C}}
  };

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SHUT  = 2'b01,
    ST_WAIT  = 2'b10,
    ST_LATCH = 2'b11
  } pspp_state_t;

  typedef enum logic [2:0] {
    FK_NONE  = 3'b000,
    FK_OVP   = 3'b001,
    FK_UVP   = 3'b010,
    FK_OCP   = 3'b011,
    FK_OTHER = 3'b100,
    FK_OFF   = 3'b101
  } pspp_fault_t;

endpackage

// ---- design/pspp_dbnc_if.sv ----
/*
  Interface between the protection logic and a debounce counter.
  Assumes both ends run on the same clock.
*/
interface pspp_dbnc_if;
  logic cond;
  logic hit;
  modport ctrl (output cond, input hit);
  modport cnt  (input cond, output hit);
endinterface

// ---- design/pspp_debounce.sv ----
/*
  Debounce counter: hit rises once cond has held for CYCLES cycles.
  Assumes cond is synchronous to clk.
*/
module pspp_debounce #(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic  clk,
  input  wire logic  rst_b,
  pspp_dbnc_if.cnt   dbnc
);

  logic [31:0] count;
  wire         at_end = (count >= 32'(CYCLES - 1));

  // Count restarts whenever the condition drops out
  always_ff @(posedge clk) begin
    if (!rst_b || !dbnc.cond) begin
      count <= 32'h0000_0000;
    end else if (!at_end) begin
      count <= count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dbnc.hit <= 1'b0;
    end else begin
      dbnc.hit <= dbnc.cond && at_end;
    end
  end

endmodule

// ---- design/pspp_top.sv ----
/*
  Source power level select and output protection of a PD source.
  Assumes the PD engine, ADC and comparators sit outside; strap pins
  and comparators are asynchronous, all other inputs are on clk.
*/
// Summary of operation
// - Adjustable variant: 16 to 60 W steps
// - Small fixed variants always advertise full power
// - Large variants halve power on top pin
// - Codes 111 and 110 power profiles
// - Codes 101 and 100 power profiles
// - Codes 011, 010, 00X power profiles
// - Sample straps at reset, send capabilities
// - Resample straps when recovering from shutdown
// - Fault removes pull-up, gate off, monitors
// - Fault cleared: delay, restart at 5 V
// - Over-voltage above 120% for debounce time
// - Blank over-voltage while output changes
// - Under-voltage below 65% past debounce
// - No alert for under-voltage faults
// - Skip 65% check under programmable contract
// - Below turn-off level always faults
// - Turn-off fault holds until latch reset
// - Fixed contract over-current at 120%
// - Over-current alert on next contract, history
// - Programmable contract uses current limiting
// - New request updates the current limit
// - Alert on every entry to or exit from current limit mode
// - Status carries mode, voltage, current
module pspp_top #(
  parameter int unsigned OVP_DEBOUNCE_NS = 100000,
  parameter int unsigned UVP_DEBOUNCE_NS = 100000,
  parameter int unsigned OVP_BLANK_NS    = 1000000,
  parameter int unsigned RESTART_MS      = 2000
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  variant,
  input  wire logic        power_halve_select,
  input  wire logic        power_step_select_hi,
  input  wire logic        power_step_select_lo,
  input  wire logic        soft_reset_done,
  input  wire logic        hard_reset_done,
  input  wire logic        explicit_contract,
  input  wire logic        contract_pps,
  input  wire logic        request_update,
  input  wire logic [15:0] requested_mv,
  input  wire logic [15:0] requested_ma,
  input  wire logic [15:0] sense_mv,
  input  wire logic [15:0] sense_ma,
  input  wire logic        below_turnoff,
  input  wire logic        below_latch_reset,
  input  wire logic        other_fault,
  output logic             cc_pullup_en,
  output logic             vbus_gate_en,
  output logic             restart_5v,
  output logic             send_caps,
  output logic [9:0]       pdp_tenth_w,
  output pspp_pkg::pspp_cur_t pdo_current,
  output logic             output_overvoltage_fault,
  output logic             output_undervoltage_fault,
  output logic             output_overcurrent_fault,
  output logic             alert_req,
  output logic             alert_ocp,
  output logic             alert_mode_change,
  output logic             ocp_history,
  output logic             current_limit_mode,
  output logic             constant_voltage_mode,
  output logic [15:0]      current_limit_ma,
  output logic [15:0]      status_mv,
  output logic [15:0]      status_ma
);

  localparam int unsigned OVP_DBNC_CYC =
    (OVP_DEBOUNCE_NS + pspp_pkg::CLK_PERIOD_NS - 1) /
    pspp_pkg::CLK_PERIOD_NS;
  localparam int unsigned UVP_DBNC_CYC =
    (UVP_DEBOUNCE_NS + pspp_pkg::CLK_PERIOD_NS - 1) /
    pspp_pkg::CLK_PERIOD_NS;
  localparam int unsigned OVP_BLANK_CYC =
    (OVP_BLANK_NS + pspp_pkg::CLK_PERIOD_NS - 1) /
    pspp_pkg::CLK_PERIOD_NS;
  localparam int unsigned RESTART_CYC =
    RESTART_MS * (1000000 / pspp_pkg::CLK_PERIOD_NS);

  function automatic logic [31:0] scaled(input logic [15:0] v,
                                         input logic [7:0]  pct);
    scaled = 32'(v) * 32'(pct);
  endfunction

  // Two-flop synchronisers for pins and comparators
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= {below_latch_reset, below_turnoff, power_halve_select,
                   power_step_select_hi, power_step_select_lo};
      pin_sync <= pin_meta;
    end
  end

  wire       latch_reset_s = pin_sync[4];
  wire       turnoff_s     = pin_sync[3];
  wire [2:0] strap_s       = pin_sync[2:0];

  pspp_pkg::pspp_state_t state;
  pspp_pkg::pspp_state_t next_state;
  pspp_pkg::pspp_fault_t fault_kind;
  pspp_pkg::pspp_fault_t next_fault_kind;

  wire run = (state == pspp_pkg::ST_RUN);

  // Fault conditions
  wire ovp_raw = scaled(sense_mv, pspp_pkg::PCT_FULL) >
                 scaled(requested_mv, pspp_pkg::PCT_OVP);
  wire uvp_raw = scaled(sense_mv, pspp_pkg::PCT_FULL) <
                 scaled(requested_mv, pspp_pkg::PCT_UVP);
  wire ocp_raw = !contract_pps &&
                 (scaled(sense_ma, pspp_pkg::PCT_FULL) >=
                  scaled(requested_ma, pspp_pkg::PCT_OCP));

  // Over-voltage blanking after a change of requested voltage
  logic [15:0] last_req_mv;
  logic [31:0] blank_cnt;
  wire         req_moving = (requested_mv != last_req_mv);
  wire         blanked    = req_moving || (blank_cnt != 32'h0000_0000);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      last_req_mv <= 16'h0000;
      blank_cnt   <= 32'h0000_0000;
    end else begin
      last_req_mv <= requested_mv;
      if (requested_mv != last_req_mv) begin
        blank_cnt <= 32'(OVP_BLANK_CYC);
      end else if (blanked) begin
        blank_cnt <= blank_cnt - 32'h0000_0001;
      end
    end
  end

  pspp_dbnc_if ovp_dbnc ();
  pspp_dbnc_if uvp_dbnc ();

  assign ovp_dbnc.cond = run && !blanked && ovp_raw;
  assign uvp_dbnc.cond = run && !contract_pps && uvp_raw;

  pspp_debounce #(.CYCLES(OVP_DBNC_CYC)) u_ovp_dbnc (
    .clk   (clk),
    .rst_b (rst_b),
    .dbnc  (ovp_dbnc)
  );

  pspp_debounce #(.CYCLES(UVP_DBNC_CYC)) u_uvp_dbnc (
    .clk   (clk),
    .rst_b (rst_b),
    .dbnc  (uvp_dbnc)
  );

  wire off_trip = run && turnoff_s;
  wire ovp_trip = run && ovp_dbnc.hit;
  wire ocp_trip = run && ocp_raw;
  wire uvp_trip = run && uvp_dbnc.hit;
  wire oth_trip = run && other_fault;

  // Fault still present while output is shut off
  wire still_bad =
    (fault_kind == pspp_pkg::FK_OVP)   ? ovp_raw :
    (fault_kind == pspp_pkg::FK_OCP)   ? ocp_raw :
    (fault_kind == pspp_pkg::FK_OTHER) ? other_fault : 1'b0;

  // Auto-restart delay counter
  logic [31:0] wait_cnt;
  wire         wait_done = (wait_cnt >= 32'(RESTART_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rst_b || state != pspp_pkg::ST_WAIT) begin
      wait_cnt <= 32'h0000_0000;
    end else if (!wait_done) begin
      wait_cnt <= wait_cnt + 32'h0000_0001;
    end
  end

  logic recover;

  always_comb begin
    next_state      = state;
    next_fault_kind = fault_kind;
    recover         = 1'b0;
    case (state)
      pspp_pkg::ST_RUN: begin
        if (off_trip) begin
          next_state      = pspp_pkg::ST_LATCH;
          next_fault_kind = pspp_pkg::FK_OFF;
        end else if (ovp_trip) begin
          next_state      = pspp_pkg::ST_SHUT;
          next_fault_kind = pspp_pkg::FK_OVP;
        end else if (ocp_trip) begin
          next_state      = pspp_pkg::ST_SHUT;
          next_fault_kind = pspp_pkg::FK_OCP;
        end else if (uvp_trip) begin
          next_state      = pspp_pkg::ST_SHUT;
          next_fault_kind = pspp_pkg::FK_UVP;
        end else if (oth_trip) begin
          next_state      = pspp_pkg::ST_SHUT;
          next_fault_kind = pspp_pkg::FK_OTHER;
        end
      end
      pspp_pkg::ST_SHUT: begin
        if (!still_bad) begin
          next_state = pspp_pkg::ST_WAIT;
        end
      end
      pspp_pkg::ST_WAIT: begin
        if (still_bad) begin
          next_state = pspp_pkg::ST_SHUT;
        end else if (wait_done) begin
          next_state      = pspp_pkg::ST_RUN;
          next_fault_kind = pspp_pkg::FK_NONE;
          recover         = 1'b1;
        end
      end
      pspp_pkg::ST_LATCH: begin
        if (latch_reset_s) begin
          next_state      = pspp_pkg::ST_RUN;
          next_fault_kind = pspp_pkg::FK_NONE;
          recover         = 1'b1;
        end
      end
      default: begin
        next_state      = pspp_pkg::ST_SHUT;
        next_fault_kind = pspp_pkg::FK_OTHER;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state        <= pspp_pkg::ST_RUN;
      fault_kind   <= pspp_pkg::FK_NONE;
      cc_pullup_en <= 1'b0;
      vbus_gate_en <= 1'b0;
      restart_5v   <= 1'b0;
    end else begin
      state        <= next_state;
      fault_kind   <= next_fault_kind;
      cc_pullup_en <= (next_state == pspp_pkg::ST_RUN);
      vbus_gate_en <= (next_state == pspp_pkg::ST_RUN);
      restart_5v   <= recover;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      output_overvoltage_fault  <= 1'b0;
      output_undervoltage_fault <= 1'b0;
      output_overcurrent_fault  <= 1'b0;
    end else begin
      output_overvoltage_fault  <= (next_fault_kind == pspp_pkg::FK_OVP);
      output_undervoltage_fault <= (next_fault_kind == pspp_pkg::FK_UVP) ||
                                   (next_fault_kind == pspp_pkg::FK_OFF);
      output_overcurrent_fault  <= (next_fault_kind == pspp_pkg::FK_OCP);
    end
  end

  // Strap sampling and capability selection
  logic [1:0] settle;
  wire        take_reset = (settle == pspp_pkg::SETTLE_TAKE);
  wire        take = take_reset || soft_reset_done || hard_reset_done ||
                     recover;

  wire [2:0] sel_code =
    (variant == pspp_pkg::VAR_ADJUST) ? strap_s :
    (variant == pspp_pkg::VAR_HALVE && strap_s[2]) ?
      pspp_pkg::CODE_HALF :
      pspp_pkg::CODE_FULL;

  wire pspp_pkg::pspp_caps_t sel_caps =
    pspp_pkg::CAPS_TABLE[sel_code];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      settle      <= pspp_pkg::SETTLE_START;
      send_caps   <= 1'b0;
      pdp_tenth_w <= 10'h000;
      pdo_current <= '0;
    end else begin
      if (settle != 2'h0) begin
        settle <= settle - 2'h1;
      end
      send_caps <= take;
      if (take) begin
        pdp_tenth_w <= sel_caps.pdp;
        pdo_current <= sel_caps.cur;
      end
    end
  end

  // Over-current reporting
  wire ocp_enter = ocp_trip && !off_trip && !ovp_trip;
  logic ocp_pending;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ocp_pending <= 1'b0;
      ocp_history <= 1'b0;
    end else begin
      if (ocp_enter) begin
        ocp_pending <= 1'b1;
      end else if (explicit_contract) begin
        ocp_pending <= 1'b0;
      end
      if (ocp_enter) begin
        ocp_history <= 1'b1;
      end else if (hard_reset_done) begin
        ocp_history <= 1'b0;
      end
    end
  end

  // Current limit versus constant voltage under programmable contracts
  wire next_cl = run && contract_pps &&
                 (sense_ma >= current_limit_ma);
  wire mode_flip = (next_cl != current_limit_mode);
  wire ocp_alert = explicit_contract && ocp_pending;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      current_limit_ma <= 16'h0000;
    end else if (request_update || explicit_contract) begin
      current_limit_ma <= requested_ma;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      current_limit_mode    <= 1'b0;
      constant_voltage_mode <= 1'b0;
      status_mv             <= 16'h0000;
      status_ma             <= 16'h0000;
    end else begin
      current_limit_mode    <= next_cl;
      constant_voltage_mode <= run && contract_pps && !next_cl;
      status_mv             <= sense_mv;
      status_ma             <= sense_ma;
    end
  end

  // Alerts come only from pending over-current and mode changes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      alert_req         <= 1'b0;
      alert_ocp         <= 1'b0;
      alert_mode_change <= 1'b0;
    end else begin
      alert_req         <= ocp_alert || mode_flip;
      alert_ocp         <= ocp_alert;
      alert_mode_change <= mode_flip;
    end
  end

endmodule

// ---- tb/pspp_monitor.sv ----
/*
  Concurrent checks on the ports of the power select and protection top.
  Assumes one clock domain and the synchronous active-low reset.
*/
module pspp_monitor #(
  parameter int unsigned OVP_DEBOUNCE_NS = 50
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [1:0]  variant,
  input wire logic        soft_reset_done,
  input wire logic        hard_reset_done,
  input wire logic        contract_pps,
  input wire logic [15:0] requested_mv,
  input wire logic [15:0] requested_ma,
  input wire logic [15:0] sense_mv,
  input wire logic [15:0] sense_ma,
  input wire logic        cc_pullup_en,
  input wire logic        vbus_gate_en,
  input wire logic        restart_5v,
  input wire logic        send_caps,
  input wire logic [9:0]  pdp_tenth_w,
  input wire logic        output_overvoltage_fault,
  input wire logic        output_overcurrent_fault,
  input wire logic        alert_req,
  input wire logic        alert_ocp,
  input wire logic        alert_mode_change,
  input wire logic        current_limit_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned OVD = OVP_DEBOUNCE_NS / pspp_pkg::CLK_PERIOD_NS;
  logic [7:0] ov_run;
  wire        ov_cond = 32'(sense_mv) * 100 > 32'(requested_mv) * 120;
  wire        oc_cond = 32'(sense_ma) * 100 >= 32'(requested_ma) * 120;

  // Consecutive cycles of over-voltage at the inputs
  always_ff @(posedge clk) begin
    if (!rst_b || !ov_cond) ov_run <= 8'h00;
    else if (ov_run != 8'hFF) ov_run <= ov_run + 8'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_gate_pair: assert property (
    cc_pullup_en == vbus_gate_en) else $error("pull-up and gate differ");
  chk_ocp_trip: assert property (
    vbus_gate_en && !contract_pps && oc_cond |=> !vbus_gate_en)
    else $error("over-current did not shut off");
  chk_ovp_debounce: assert property (
    $rose(output_overvoltage_fault) |-> ov_run >= 8'(OVD - 1))
    else $error("over-voltage fault too early");
  chk_pps_no_ocp: assert property (
    $rose(output_overcurrent_fault) |-> !$past(contract_pps))
    else $error("over-current trip under pps");
  chk_take_caps: assert property (
    soft_reset_done || hard_reset_done |=> send_caps)
    else $error("no capabilities after reset message");
  chk_restart_caps: assert property (
    restart_5v |-> vbus_gate_en && send_caps)
    else $error("restart without capabilities");
  chk_fixed_full: assert property (
    send_caps && $past(variant) == pspp_pkg::VAR_FIXED
      |-> pdp_tenth_w == 10'h258) else $error("fixed variant not full");
  chk_alert_cause: assert property (
    alert_req |-> alert_ocp || alert_mode_change)
    else $error("alert without cause");
  chk_mode_alert: assert property (
    $changed(current_limit_mode) |-> ##[0:1] alert_req && alert_mode_change)
    else $error("mode change without alert");

  cov_restart: cover property (restart_5v);
  cov_ocp_alert: cover property (alert_ocp);
  cov_limit: cover property (current_limit_mode);
endmodule

bind pspp_top pspp_monitor #(.OVP_DEBOUNCE_NS(OVP_DEBOUNCE_NS)) i_pspp_monitor (
  .clk, .rst_b, .variant, .soft_reset_done, .hard_reset_done, .contract_pps,
  .requested_mv, .requested_ma, .sense_mv, .sense_ma, .cc_pullup_en,
  .vbus_gate_en, .restart_5v, .send_caps, .pdp_tenth_w,
  .output_overvoltage_fault, .output_overcurrent_fault, .alert_req,
  .alert_ocp, .alert_mode_change, .current_limit_mode
);

// ---- tb/pspp_sink_model.sv ----
/*
  Sink on the far side: negotiates contracts and sends requests.
  Assumes the bench calls negotiate from its main sequence.
*/
module pspp_sink_model (
  input  wire logic clk,
  output logic      explicit_contract,
  output logic      request_update,
  output logic      contract_pps,
  output logic [15:0] requested_mv,
  output logic [15:0] requested_ma
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    explicit_contract = 1'b0;
    request_update = 1'b0;
    contract_pps = 1'b0;
    requested_mv = 16'h1388;
    requested_ma = 16'h0BB8;
  end

  // Request and contract in one cycle, after an optional slow wait
  task automatic negotiate(input logic pps, input logic [15:0] mv, ma,
                           input int slow);
    repeat (slow) @(posedge clk);
    @(posedge clk);
    #1;
    contract_pps = pps;
    requested_mv = mv;
    requested_ma = ma;
    request_update = 1'b1;
    explicit_contract = 1'b1;
    @(posedge clk);
    #1;
    request_update = 1'b0;
    explicit_contract = 1'b0;
  endtask
endmodule

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the power select and protection top.
  Assumes the sink model drives the contract side.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, soft_reset_done, hard_reset_done, below_turnoff;
  logic below_latch_reset, other_fault;
  logic power_halve_select, power_step_select_hi, power_step_select_lo;
  logic [1:0] variant;
  logic [15:0] sense_mv, sense_ma, requested_mv, requested_ma;
  logic explicit_contract, contract_pps, request_update;
  logic cc_pullup_en, vbus_gate_en, restart_5v, send_caps, alert_req;
  logic output_overvoltage_fault, output_undervoltage_fault;
  logic output_overcurrent_fault, alert_ocp, alert_mode_change, ocp_history;
  logic current_limit_mode, constant_voltage_mode;
  logic [9:0] pdp_tenth_w;
  logic [15:0] current_limit_ma, status_mv, status_ma;
  pspp_pkg::pspp_cur_t pdo_current;
  int mismatches, comparisons, n_ocp, n_mode, n_alert, seed, k, r;
  int exp_q[$];
  localparam logic [9:0] PWR [8] = '{10'h0A0, 10'h0A0, 10'h0E1, 10'h12C,
                                     10'h177, 10'h1C2, 10'h20D, 10'h258};
  localparam logic [8:0] AMP [8][5] = '{
    '{9'h12C, 9'h0B1, 9'h085, 9'h000, 9'h000},
    '{9'h12C, 9'h0B1, 9'h085, 9'h000, 9'h000},
    '{9'h12C, 9'h0F4, 9'h0B7, 9'h000, 9'h000},
    '{9'h12C, 9'h12C, 9'h0FA, 9'h0C8, 9'h000},
    '{9'h12C, 9'h12C, 9'h12C, 9'h0F6, 9'h000},
    '{9'h12C, 9'h12C, 9'h12C, 9'h12C, 9'h0E1},
    '{9'h12C, 9'h12C, 9'h12C, 9'h12C, 9'h104},
    '{9'h12C, 9'h12C, 9'h12C, 9'h12C, 9'h12C}};

  pspp_top #(.OVP_DEBOUNCE_NS(50), .UVP_DEBOUNCE_NS(50), .OVP_BLANK_NS(100),
             .RESTART_MS(1)) i_pspp_top (.*);
  pspp_sink_model i_pspp_sink_model (.clk, .explicit_contract,
    .request_update, .contract_pps, .requested_mv, .requested_ma);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cmp(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic set_code(input logic [2:0] c);
    {power_halve_select, power_step_select_hi, power_step_select_lo} = c;
  endtask

  function automatic int row();
    if (variant == pspp_pkg::VAR_ADJUST)
      return {power_halve_select, power_step_select_hi, power_step_select_lo};
    if (variant == pspp_pkg::VAR_HALVE && power_halve_select) return 3;
    return 7;
  endfunction

  task automatic take(input bit hard);
    exp_q.push_back(row());
    if (hard) hard_reset_done = 1'b1;
    else soft_reset_done = 1'b1;
    step(1);
    {hard_reset_done, soft_reset_done} = 2'b00;
    step(2);
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    step(12);
    exp_q.push_back(row());
    rst_b = 1'b1;
    step(5);
  endtask

  task automatic wait_off();
    for (k = 0; k < 30 && vbus_gate_en !== 1'b0; k++) step(1);
  endtask

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Result watcher: capability notes and alert tallies
  always @(negedge clk) begin
    if (alert_req === 1'b1) begin
      n_alert++;
      if (alert_ocp === 1'b1) n_ocp++;
      if (alert_mode_change === 1'b1) n_mode++;
    end
    if (send_caps === 1'b1) begin
      if (exp_q.size() == 0) cmp("unexpected_caps", 16'h0000, 16'h0001);
      else begin
        int q;
        q = exp_q.pop_front();
        cmp("pdp", 16'(PWR[q]), 16'(pdp_tenth_w));
        for (int j = 0; j < 5; j++)
          cmp("pdo_cur", 16'(AMP[q][j]), 16'(pdo_current[j]));
      end
    end
  end

  initial begin
    repeat (101000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    seed = 32'h179C72F4;
    {rst_b, soft_reset_done, hard_reset_done, below_turnoff} = 4'h0;
    {below_latch_reset, other_fault} = 2'h0;
    variant = pspp_pkg::VAR_ADJUST;
    set_code(3'h7);
    sense_mv = 16'h1388;
    sense_ma = 16'h0000;
    do_reset();
    for (int i = 0; i < 12; i++) begin
      set_code(i < 8 ? 3'(i) : 3'($random(seed)));
      step(3);
      take(i[0]);
    end
    variant = pspp_pkg::VAR_FIXED;
    set_code(3'($random(seed)));
    step(3);
    take(0);
    variant = pspp_pkg::VAR_HALVE;
    set_code(3'h4);
    step(3);
    take(1);
    set_code(3'h3);
    step(3);
    take(0);
    variant = pspp_pkg::VAR_ADJUST;
    set_code(3'h6);
    step(10);
    i_pspp_sink_model.negotiate(1'b1, 16'h1388, 16'h03E8, 2);
    r = n_mode;
    sense_mv = 16'h0BB8;
    sense_ma = 16'h04B0;
    step(4);
    cmp("cl_mode", 16'h0001, 16'(current_limit_mode));
    cmp("uv_fault", 16'h0000, 16'(output_undervoltage_fault));
    cmp("status_ma", 16'h04B0, status_ma);
    cmp("status_mv", 16'h0BB8, status_mv);
    i_pspp_sink_model.negotiate(1'b1, 16'h1388, 16'h07D0, 0);
    step(3);
    cmp("limit_ma", 16'h07D0, current_limit_ma);
    cmp("cv_mode", 16'h0001, 16'(constant_voltage_mode));
    cmp("mode_alerts", 16'(r + 2), 16'(n_mode));
    sense_mv = 16'h1388;
    sense_ma = 16'h0000;
    below_turnoff = 1'b1;
    wait_off();
    cmp("uv_fault", 16'h0001, 16'(output_undervoltage_fault));
    below_turnoff = 1'b0;
    step(20);
    cmp("gate_latched", 16'h0000, 16'(vbus_gate_en));
    do_reset();
    i_pspp_sink_model.negotiate(1'b0, 16'h2328, 16'h0BB8, 0);
    sense_mv = 16'h2328;
    step(12);
    i_pspp_sink_model.negotiate(1'b0, 16'h1388, 16'h0BB8, 0);
    step(7);
    cmp("ov_blank", 16'h0000, 16'(output_overvoltage_fault));
    sense_mv = 16'h1388;
    step(4);
    repeat (2) begin
      sense_mv = 16'h17D4;
      step(3);
      sense_mv = 16'h1388;
      step(1);
    end
    step(10);
    cmp("ov_glitch", 16'h0000, 16'(output_overvoltage_fault));
    sense_mv = 16'h17D4;
    wait_off();
    cmp("ov_fault", 16'h0001, 16'(output_overvoltage_fault));
    cmp("cc_pullup", 16'h0000, 16'(cc_pullup_en));
    sense_mv = 16'h1388;
    do_reset();
    r = n_alert;
    sense_mv = 16'h0C80;
    wait_off();
    cmp("uv_fault", 16'h0001, 16'(output_undervoltage_fault));
    cmp("uv_alerts", 16'(r), 16'(n_alert));
    sense_mv = 16'h1388;
    set_code(3'h7);
    do_reset();
    sense_ma = 16'h0E10;
    wait_off();
    cmp("oc_fault", 16'h0001, 16'(output_overcurrent_fault));
    cmp("oc_hist", 16'h0001, 16'(ocp_history));
    sense_ma = 16'h0000;
    set_code(3'h5);
    exp_q.push_back(5);
    for (k = 0; k < 100300 && restart_5v !== 1'b1; k++) step(1);
    cmp("restart_5v", 16'h0001, 16'(restart_5v));
    step(3);
    r = n_ocp;
    i_pspp_sink_model.negotiate(1'b0, 16'h1388, 16'h0BB8, 0);
    step(2);
    cmp("ocp_alert", 16'(r + 1), 16'(n_ocp));
    other_fault = 1'b1;
    wait_off();
    cmp("other_cc", 16'h0000, 16'(cc_pullup_en));
    close_out();
  end
endmodule
